// ---- src/tmr_pkg.sv ----
// Package with register map, field layout and constants of the timer channel.
`default_nettype none
package tmr_pkg;
	localparam int ADR_W = 4;
	localparam logic [ADR_W-1:0] OFS_COUNT = 4'h0;
	localparam logic [ADR_W-1:0] OFS_CTRL = 4'h4;
	localparam logic [ADR_W-1:0] OFS_STAT = 4'h8;

	localparam int CTL_START = 0;
	localparam int CTL_OS_START = 1;
	localparam int CTL_MODE = 2;
	localparam int CTL_PWM8 = 3;
	localparam int CTL_CSEL_LO = 4;
	localparam int CTL_POUT = 6;
	localparam int CTL_TSEL_LO = 7;
	localparam int CTL_TWO_PH = 9;
	localparam int CTL_MUL4 = 10;
	localparam int CTL_PORT = 11;

	localparam int ST_RUN = 0;
	localparam int ST_OUT = 1;
	localparam int ST_PIN = 2;
	localparam int ST_HIGH = 3;
	localparam int ST_MUL4 = 4;

	typedef enum logic [1:0]
	{
		CS_DIV1 = 2'h0,
		CS_DIV8 = 2'h1,
		CS_DIV32 = 2'h2,
		CS_SUB32 = 2'h3
	} tmr_csel_e;

	typedef enum logic [1:0]
	{
		TS_SOFT = 2'h0,
		TS_FALL = 2'h1,
		TS_RISE = 2'h2,
		TS_OVF = 2'h3
	} tmr_tsel_e;

	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1f;
	localparam logic [15:0] PWM16_PERIOD = 16'hffff;
	localparam logic [15:0] PWM8_PERIOD = 16'h00ff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [7:0] UNIT_ZERO = 8'h00;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : tmr_pkg
`default_nettype wire

// ---- src/tmr_oneshot_pwm.sv ----
// Timer channel with one-shot and PWM modes behind a Wishbone slave.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`default_nettype none
// How it works
// - One-shot counts n ticks, reloads, then stops.
// - Trigger during one-shot count reloads and restarts.
// - One-shot starts on pin, overflow, software flag.
// - Clearing start flag stops counting in both modes.
// - One-shot raises request when count hits zero.
// - Pins act as plain port or timer pins.
// - Count register read is undefined in these modes.
// - Write while stopped loads reload and counter.
// - Write while running loads reload register only.
// - PWM counts down, 16-bit or 8-bit width.
// - PWM reloads at each rising and each falling output edge.
// - PWM ignores triggers once counting has started.
// - 16-bit PWM: n high, period 65535 ticks.
// - 8-bit PWM: n(m+1) high, 255(m+1) period.
// - PWM starts on pin, overflow, or start flag.
// - Multiply-by-4 takes effect only on third channel.
module tmr_oneshot_pwm #(
	parameter bit IS_THIRD_CHANNEL = 1'b0
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tmr_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins and neighbouring logic.
	input wire logic timer_trigger_input_i,
	input wire logic subclock_i,
	input wire logic overflow_i,
	output logic timer_pulse_output_o,
	output logic irq_req_o
);
	import tmr_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [15:0] cnt;
		logic [15:0] reload;
		logic [7:0] unit;
		logic run;
		logic high;
		logic out;
		logic pin;
		logic irq;
		logic start;
		logic mode_pwm;
		logic pwm8;
		logic [1:0] csel;
		logic pout;
		logic [1:0] tsel;
		logic two_ph;
		logic mul4;
		logic port_lvl;
		logic [4:0] pre;
		logic [4:0] sub_div;
		logic trg_s1;
		logic trg_s2;
		logic trg_prev;
		logic sub_s1;
		logic sub_s2;
		logic sub_prev;
		logic pin_q;
	} tmr_state_s;

	// The whole channel state lives in one registered struct. The pulse pin
	// has its own bit, so the pin is a flip-flop and never glitches when
	// the mode, the pulse enable and the port level change in one write.

	tmr_state_s s_r;
	tmr_state_s s_nxt;

	logic req;
	logic wr_cnt;
	logic wr_ctl;
	logic tick;
	logic utick;
	logic sub_edge;
	logic trig;
	logic sw_os;
	logic sw_go;
	logic [15:0] new_reload;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	logic [15:0] period;
	logic stop_now;
	logic pin_level;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		req = wb_cyc_i && wb_stb_i && !s_r.ack;
		wr_cnt = req && wb_we_i && (wb_adr_i == OFS_COUNT);
		wr_ctl = req && wb_we_i && (wb_adr_i == OFS_CTRL) && wb_sel_i[0];

		// Bus answer: one registered ack per request, unmapped reads zero.
		s_nxt.ack = req;
		s_nxt.dat = RESET_ZERO;
		if (req && !wb_we_i)
		begin
			unique case (wb_adr_i)
				OFS_COUNT: s_nxt.dat[15:0] = s_r.cnt;
				OFS_CTRL:
				begin
					s_nxt.dat[CTL_START] = s_r.start;
					s_nxt.dat[CTL_MODE] = s_r.mode_pwm;
					s_nxt.dat[CTL_PWM8] = s_r.pwm8;
					s_nxt.dat[CTL_CSEL_LO+:2] = s_r.csel;
					s_nxt.dat[CTL_POUT] = s_r.pout;
					s_nxt.dat[CTL_TSEL_LO+:2] = s_r.tsel;
					s_nxt.dat[CTL_TWO_PH] = s_r.two_ph;
					s_nxt.dat[CTL_MUL4] = s_r.mul4;
					s_nxt.dat[CTL_PORT] = s_r.port_lvl;
				end
				OFS_STAT:
				begin
					s_nxt.dat[ST_RUN] = s_r.run;
					s_nxt.dat[ST_OUT] = s_r.out;
					s_nxt.dat[ST_PIN] = s_r.pin;
					s_nxt.dat[ST_HIGH] = s_r.high;
					s_nxt.dat[ST_MUL4] = s_r.two_ph && s_r.mul4 && IS_THIRD_CHANNEL;
				end
				default: s_nxt.dat = RESET_ZERO;
			endcase
		end

		new_reload = s_r.reload;
		if (wb_sel_i[0])
			new_reload[7:0] = wb_dat_i[7:0];
		if (wb_sel_i[1])
			new_reload[15:8] = wb_dat_i[15:8];
		if (wr_cnt)
		begin
			s_nxt.reload = new_reload;
			if (!s_r.run)
				s_nxt.cnt = new_reload;
		end

		sw_os = wr_ctl && wb_dat_i[CTL_OS_START];
		sw_go = wr_ctl && wb_dat_i[CTL_START] && !s_r.start;
		if (wr_ctl)
		begin
			s_nxt.start = wb_dat_i[CTL_START];
			s_nxt.mode_pwm = wb_dat_i[CTL_MODE];
			s_nxt.pwm8 = wb_dat_i[CTL_PWM8];
			s_nxt.csel = wb_dat_i[CTL_CSEL_LO+:2];
			s_nxt.pout = wb_dat_i[CTL_POUT];
			s_nxt.tsel = wb_dat_i[CTL_TSEL_LO+:2];
			s_nxt.two_ph = wb_dat_i[CTL_TWO_PH];
			s_nxt.mul4 = wb_dat_i[CTL_MUL4];
			s_nxt.port_lvl = wb_dat_i[CTL_PORT];
		end

		// Two-flop synchronisers for the pins.
		s_nxt.trg_s1 = timer_trigger_input_i;
		s_nxt.trg_s2 = s_r.trg_s1;
		s_nxt.trg_prev = s_r.trg_s2;
		s_nxt.pin = s_r.trg_s2;
		s_nxt.sub_s1 = subclock_i;
		s_nxt.sub_s2 = s_r.sub_s1;
		s_nxt.sub_prev = s_r.sub_s2;
		sub_edge = s_r.sub_s2 && !s_r.sub_prev;

		s_nxt.pre = s_r.pre + 5'h01;
		if (sub_edge)
			s_nxt.sub_div = s_r.sub_div + 5'h01;
		unique case (tmr_csel_e'(s_r.csel))
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = (s_r.pre[2:0] == DIV8_LAST[2:0]);
			CS_DIV32: tick = (s_r.pre == DIV32_LAST);
			CS_SUB32: tick = sub_edge && (s_r.sub_div == DIV32_LAST);
		endcase

		unique case (tmr_tsel_e'(s_r.tsel))
			TS_SOFT: trig = 1'b0;
			TS_FALL: trig = !s_r.trg_s2 && s_r.trg_prev;
			TS_RISE: trig = s_r.trg_s2 && !s_r.trg_prev;
			TS_OVF: trig = overflow_i;
		endcase

		// Unit prescale by m+1 in 8-bit PWM.
		utick = tick && (!s_r.pwm8 || (s_r.unit == UNIT_ZERO));
		if (tick && s_r.run && s_r.pwm8)
			s_nxt.unit = (s_r.unit == UNIT_ZERO) ? s_r.reload[7:0]
				: s_r.unit - 8'h01;
		// Width and period per PWM size.
		period = s_r.pwm8 ? PWM8_PERIOD : PWM16_PERIOD;
		hi_len = s_r.pwm8 ? {8'h00, s_r.reload[15:8]} : s_r.reload;
		lo_len = period - hi_len;

		// A write that clears the start flag stops the channel at the edge
		// that takes it. Waiting for the flag to settle first would let the
		// old mode run one more tick and could raise the pin after a stop.
		stop_now = wr_ctl && !wb_dat_i[CTL_START];

		// In one-shot mode a set value of zero or one ends after one tick.
		// In PWM mode a width of zero keeps the pin low for whole periods,
		// and a width equal to the period keeps it high.
		if (!s_r.start || stop_now)
		begin
			s_nxt.run = 1'b0;
			s_nxt.out = 1'b0;
			s_nxt.high = 1'b0;
			if (sw_os && !s_r.mode_pwm && wb_dat_i[CTL_START])
			begin
				s_nxt.cnt = s_r.reload;
				s_nxt.run = 1'b1;
				s_nxt.out = 1'b1;
				s_nxt.high = 1'b1;
			end
		end
		else if (!s_r.mode_pwm)
		begin
			if (trig || sw_os)
			begin
				s_nxt.cnt = s_r.reload;
				s_nxt.run = 1'b1;
				s_nxt.out = 1'b1;
				s_nxt.high = 1'b1;
			end
			else if (s_r.run && tick)
			begin
				if (s_r.cnt <= CNT_ONE)
				begin
					s_nxt.cnt = s_r.reload;
					s_nxt.run = 1'b0;
					s_nxt.out = 1'b0;
					s_nxt.high = 1'b0;
					s_nxt.irq = 1'b1;
				end
				else
					s_nxt.cnt = s_r.cnt - CNT_ONE;
			end
		end
		else if (!s_r.run)
		begin
			if (trig || sw_os || (s_r.tsel == TS_SOFT))
			begin
				s_nxt.run = 1'b1;
				s_nxt.unit = s_r.reload[7:0];
				s_nxt.high = (hi_len != CNT_ZERO);
				s_nxt.out = (hi_len != CNT_ZERO);
				s_nxt.cnt = (hi_len != CNT_ZERO) ? hi_len : lo_len;
			end
		end
		else if (utick)
		begin
			if (s_r.cnt > CNT_ONE)
				s_nxt.cnt = s_r.cnt - CNT_ONE;
			else if (s_r.high && (lo_len != CNT_ZERO))
			begin
				s_nxt.high = 1'b0;
				s_nxt.out = 1'b0;
				s_nxt.cnt = lo_len;
				s_nxt.irq = 1'b1;
			end
			else if (hi_len != CNT_ZERO)
			begin
				s_nxt.high = 1'b1;
				s_nxt.out = 1'b1;
				s_nxt.cnt = hi_len;
			end
			else
				s_nxt.cnt = lo_len;
		end

		// Pin shows pulse or port.
		// The choice is made on the next state so that the pin follows a
		// control write at the same edge as the other control bits.
		// In PWM mode the pin is always the pulse output.
		if (s_nxt.pout || s_nxt.mode_pwm)
			pin_level = s_nxt.out;
		else
			pin_level = s_nxt.port_lvl;
		s_nxt.pin_q = pin_level;

		// A one-shot software start write is taken at once; a PWM start flag write with software trigger select starts the count one edge later.
		// Its one-shot start bit is
		// a pulse and is never stored, so it reads back as zero.
		if (sw_go && s_r.mode_pwm)
			s_nxt.unit = s_nxt.unit;
	end

	// Software must treat the count read as undefined in these modes. The
	// value shown is the live counter and may change between two reads of
	// the low and the high byte.

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign irq_req_o = s_r.irq;
	// The pin bit is already the selected level.
	assign timer_pulse_output_o = s_r.pin_q;
endmodule : tmr_oneshot_pwm
`default_nettype wire

// ---- bench/tmr_trig_src.sv ----
// Trigger source model that drives the timer trigger pin.
`default_nettype none
module tmr_trig_src
(
	// Clock and request.
	input wire logic clk_i,
	input wire logic fire_i,
	// Trigger pin.
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int left = 0;
	always @(posedge clk_i)
	begin
		if (fire_i)
			left <= 8;
		else if (left > 0)
			left <= left - 1;
	end
	assign pin_o = left > 0;
endmodule : tmr_trig_src
`default_nettype wire

// ---- bench/tmr_chk_sva.sv ----
// Checker of bus handshake, output pin and request of the timer.
`default_nettype none
module tmr_chk
	import tmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tmr_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic timer_pulse_output_o,
	input wire logic irq_req_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ctrl_wr;
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
			&& wb_adr_i == OFS_CTRL && wb_sel_i[0];
	endsequence
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	AST_ACK_ANSWER: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	AST_ACK_CAUSE: assert property
		($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_DAT_IDLE: assert property
		(!wb_ack_o |-> wb_dat_o == RESET_ZERO)
		else $error("read data outside ack");
	AST_RST_QUIET: assert property ($past(rst_i) |->
		!wb_ack_o && !irq_req_o && !timer_pulse_output_o)
		else $error("output active after reset");
	AST_IRQ_ONE: assert property (irq_req_o |=> !irq_req_o)
		else $error("request longer than one cycle");
	AST_STOP_PWM: assert property (s_ctrl_wr ##0
		(wb_dat_i[CTL_MODE] && !wb_dat_i[CTL_START])
		|=> !timer_pulse_output_o [*2])
		else $error("output high after stop");
	AST_PORT_LEVEL: assert property (s_ctrl_wr ##0
		(!wb_dat_i[CTL_MODE] && !wb_dat_i[CTL_POUT])
		|=> timer_pulse_output_o == $past(wb_dat_i[CTL_PORT]))
		else $error("port level wrong");
endmodule : tmr_chk
bind tmr_oneshot_pwm tmr_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.timer_pulse_output_o, .irq_req_o);
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the one-shot and PWM timer channel.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	localparam logic [31:0] B_ST = 32'h0000_0001 << CTL_START;
	localparam logic [31:0] B_OS = 32'h0000_0001 << CTL_OS_START;
	localparam logic [31:0] B_MD = 32'h0000_0001 << CTL_MODE;
	localparam logic [31:0] B_P8 = 32'h0000_0001 << CTL_PWM8;
	localparam logic [31:0] B_PO = 32'h0000_0001 << CTL_POUT;
	localparam logic [31:0] B_TP = 32'h0000_0001 << CTL_TWO_PH;
	localparam logic [31:0] B_M4 = 32'h0000_0001 << CTL_MUL4;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic fire = 1'b0, ack, pout, irq, trig;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0000_0000, q, rd;
	int err_total = 0, num_checks = 0, irqs = 0, hi, lo, n;
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (irq === 1'b1)
			irqs <= irqs + 1;
	tmr_oneshot_pwm uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.timer_trigger_input_i(trig), .subclock_i(1'b0), .overflow_i(1'b0),
		.timer_pulse_output_o(pout), .irq_req_o(irq));
	tmr_trig_src u_src (.clk_i(clk_i), .fire_i(fire), .pin_o(trig));
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", s, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// Skips a running pulse, then times the next high and low phases.
	task measure(input int lim);
		hi = 0;
		lo = 0;
		while (pout === 1'b1) @(posedge clk_i);
		while (pout !== 1'b1) @(posedge clk_i);
		while (pout === 1'b1)
		begin
			hi++;
			@(posedge clk_i);
		end
		while (pout !== 1'b1 && lo < lim)
		begin
			lo++;
			@(posedge clk_i);
		end
	endtask : measure
	task t_regs;
		wb(1'b0, OFS_STAT, 32'h0000_0000);
		chk("status", 32'h0000_0000, q);
		wb(1'b0, 4'hc, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		wb(1'b1, OFS_CTRL, 32'h0000_0001 << CTL_PORT);
		@(posedge clk_i);
		chk("port", 32'h0000_0001, {31'h0, pout});
		wb(1'b1, OFS_CTRL, B_TP | B_M4);
		wb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("two phase ctrl", B_TP | B_M4, q);
		wb(1'b0, OFS_STAT, 32'h0000_0000);
		chk("mul4 off", 32'h0000_0000, q);
		chk("port low", 32'h0000_0000, {31'h0, pout});
	endtask : t_regs
	task t_oneshot;
		wb(1'b1, OFS_COUNT, 32'h0000_0005);
		n = irqs;
		fork
			wb(1'b1, OFS_CTRL, B_ST | B_OS | B_PO);
			measure(300);
		join
		chk("shot high", 32'd5, hi);
		chk("shot stop", 32'd300, lo);
		chk("shot irq", 32'd1, irqs - n);
		wb(1'b1, OFS_CTRL, B_ST | B_PO | (32'h0000_0002 << CTL_TSEL_LO));
		fork
			begin
				@(posedge clk_i);
				fire <= 1'b1;
				@(posedge clk_i);
				fire <= 1'b0;
			end
			measure(300);
		join
		chk("pin shot", 32'd5, hi);
	endtask : t_oneshot
	task t_pwm;
		wb(1'b1, OFS_COUNT, 32'h0000_0201);
		wb(1'b1, OFS_CTRL, B_ST | B_MD | B_P8);
		n = irqs;
		measure(1000);
		chk("pwm high", 32'd4, hi);
		chk("pwm low", 32'd506, lo);
		chk("pwm irq", 32'd1, irqs - n);
		wb(1'b1, OFS_COUNT, 32'h0000_0301);
		measure(1000);
		chk("new high", 32'd6, hi);
		wb(1'b1, OFS_CTRL, B_MD);
		repeat (3) @(posedge clk_i);
		chk("stopped", 32'h0000_0000, {31'h0, pout});
	endtask : t_pwm
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	initial
	begin
		#50000;
		err_total++;
		final_report;
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_oneshot;
		t_pwm;
		final_report;
	end
endmodule : testbench
`default_nettype wire
